// file: core/pgs_power_good.sv
// Top of the power-good signal logic: two outputs with latched faults.
`timescale 1ns/1ns
`default_nettype none
module pgs_power_good #(
  parameter int unsigned GATE_CYCLES = pgs_pkg::GATE_CYCLES,
  parameter int unsigned RISE_CYCLES = pgs_pkg::RISE_CYCLES
) (
  input  wire logic                  i_core_clk,
  input  wire logic                  i_nrst,
  input  wire logic                  i_ce,
  input  wire logic                  i_otp_busy,
  input  wire logic                  i_standby_reached,
  input  wire pgs_pkg::pgs_rail_t    i_rail [pgs_pkg::N_RAIL],
  input  wire logic                  i_window_check_sel,
  input  wire logic                  i_analog_supply_input_ok,
  input  wire logic                  i_external_monitor_one_ok,
  input  wire logic                  i_external_monitor_two_ok,
  input  wire logic                  i_thermal_warn,
  input  wire logic                  i_thermal_shutdown,
  input  wire logic                  i_supply_overvoltage,
  input  wire pgs_pkg::pgs_cfg_t     i_cfg_a,
  input  wire pgs_pkg::pgs_cfg_t     i_cfg_b,
  input  wire logic [1:0]            i_clr_step_down,
  input  wire logic                  i_clr_step_up,
  input  wire logic [2:0]            i_clr_diagnostic,
  input  wire logic [2:0]            i_clr_top,
  output var  logic                  o_power_good_out_a,
  output var  logic                  o_power_good_out_b,
  output var  logic [8:0]            o_fault_latch_a,
  output var  logic [8:0]            o_fault_latch_b
);

  localparam int unsigned NR = pgs_pkg::N_RAIL;
  localparam int unsigned NF = pgs_pkg::N_FLT;

  // Invalid check shared by every rail.
  function automatic logic rail_bad(input logic uv_ok,
                                    input logic ov_ok,
                                    input logic win);
    rail_bad = ~uv_ok | (win & ~ov_ok);
  endfunction

  pgs_pkg::pgs_state_t state_q;
  pgs_pkg::pgs_state_t state_d;
  logic                run_w;
  logic                otp_exit_w;

  always_comb begin
    state_d = state_q;
    case (state_q)
      pgs_pkg::ST_LOAD: if (!i_otp_busy) state_d = pgs_pkg::ST_WAIT;
      pgs_pkg::ST_WAIT: if (i_standby_reached) state_d = pgs_pkg::ST_RUN;
      pgs_pkg::ST_RUN:  state_d = pgs_pkg::ST_RUN;
      default:          state_d = pgs_pkg::ST_LOAD;
    endcase
  end

  assign run_w      = (state_q == pgs_pkg::ST_RUN);
  assign otp_exit_w = (state_q == pgs_pkg::ST_LOAD) & ~i_otp_busy;

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) state_q <= pgs_pkg::ST_LOAD;
    else if (i_ce) state_q <= state_d;
  end

  // Per-rail live status, independent of the output.
  logic [NR-1:0] act_w;
  logic [NR-1:0] inval_w;
  logic [NR-1:0] open_w;
  logic [NR-1:0] nok_cont_w;

  for (genvar r = 0; r < NR; r++) begin : g_rail
    assign act_w[r] = i_rail[r].enabled & i_rail[r].mon_en;
    assign inval_w[r] = act_w[r] & rail_bad(i_rail[r].uv_ok,
                                            i_rail[r].ov_ok,
                                            i_window_check_sel);
    // Continuous mode has no mask: delay, ramp and invalid all count.
    assign nok_cont_w[r] = act_w[r] & (inval_w[r]
                                       | i_rail[r].start_dly
                                       | i_rail[r].ramping);

    pgs_rail_gate #(
      .CYCLES (GATE_CYCLES)
    ) u_gate (
      .i_core_clk (i_core_clk),
      .i_nrst     (i_nrst),
      .i_ce       (i_ce),
      .i_en       (i_rail[r].enabled),
      .i_restart  (i_rail[r].v_change),
      .i_hold     (i_rail[r].start_dly),
      .o_open     (open_w[r])
    );
  end

  // Input and thermal events shared by both outputs.
  logic [NF-1:NR] in_evt_w;
  assign in_evt_w[pgs_pkg::FLT_ANALOG_SUPPLY_INPUT]  = ~i_analog_supply_input_ok;
  assign in_evt_w[pgs_pkg::FLT_EXTERNAL_MONITOR_ONE] = ~i_external_monitor_one_ok;
  assign in_evt_w[pgs_pkg::FLT_EXTERNAL_MONITOR_TWO] = ~i_external_monitor_two_ok;
  assign in_evt_w[pgs_pkg::FLT_TWARN] = i_thermal_warn;
  assign in_evt_w[pgs_pkg::FLT_TSD]   = i_thermal_shutdown;
  assign in_evt_w[pgs_pkg::FLT_OVP]   = i_supply_overvoltage;

  // Clear strobes, each mapped from its owning interrupt register.
  logic [NF-1:0] clr_w;
  assign clr_w[1:0] = i_clr_step_down;
  assign clr_w[2]   = i_clr_step_up;
  assign clr_w[pgs_pkg::FLT_EXTERNAL_MONITOR_TWO:pgs_pkg::FLT_ANALOG_SUPPLY_INPUT] = i_clr_diagnostic;
  assign clr_w[pgs_pkg::FLT_OVP:pgs_pkg::FLT_TWARN]  = i_clr_top;

  pgs_pkg::pgs_cfg_t cfg_w [2];
  assign cfg_w[0] = i_cfg_a;
  assign cfg_w[1] = i_cfg_b;

  logic [NF-1:0] flt_q [2];
  logic [NF-1:0] flt_d [2];
  logic          pg_q  [2];
  logic          pg_d  [2];

  for (genvar k = 0; k < 2; k++) begin : g_out
    wire           cont_w = (cfg_w[k].gated_or_continuous_sel == pgs_pkg::MODE_CONT);
    wire [NR-1:0]  rsel_w = cfg_w[k].src_sel[NR-1:0];
    wire [NR-1:0]  rset_g_w;
    wire [NR-1:0]  rset_w;
    wire [NF-1:0]  set_w;
    wire           hold_rail_w;
    wire           hold_in_w;
    wire           live_w;
    wire           raw_w;

    // Gated mode only sees a rail once its mask window has closed.
    assign rset_g_w = rsel_w & inval_w & ~open_w;
    assign rset_w   = cont_w ? (rsel_w & inval_w) : rset_g_w;

    assign set_w[NR-1:0] = run_w ? rset_w : '0;
    assign set_w[pgs_pkg::FLT_TWARN:NR] = run_w ?
      (cfg_w[k].src_sel[pgs_pkg::FLT_TWARN:NR] & in_evt_w[pgs_pkg::FLT_TWARN:NR])
      : '0;
    // Shutdown and overvoltage always pull the output to its default.
    assign set_w[NF-1:pgs_pkg::FLT_TSD] = run_w ?
      in_evt_w[NF-1:pgs_pkg::FLT_TSD] : '0;

    // Set wins over a clear arriving in the same cycle.
    assign flt_d[k] = otp_exit_w ? pgs_pkg::FLT_RST
                                 : (set_w | (flt_q[k] & ~clr_w));

    // Gated mode stalls on any pending rail fault; continuous only on request.
    assign hold_rail_w = (|flt_q[k][NR-1:0])
                         & (~cont_w | cfg_w[k].fault_holds_output);
    assign hold_in_w = |flt_q[k][NF-1:NR];

    assign live_w = cont_w ? (|(rsel_w & nok_cont_w))
                           : (|set_w);

    assign raw_w = run_w & ~live_w & ~hold_rail_w & ~hold_in_w & ~(|set_w);

    pgs_rise_delay #(
      .CYCLES (RISE_CYCLES)
    ) u_rise (
      .i_core_clk (i_core_clk),
      .i_nrst     (i_nrst),
      .i_ce       (i_ce),
      .i_good     (raw_w),
      .i_option   (cfg_w[k].assert_delay_option),
      .o_good     (pg_d[k])
    );

    always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
        flt_q[k] <= pgs_pkg::FLT_RST;
        pg_q[k]  <= pgs_pkg::PG_RST;
      end else if (i_ce) begin
        flt_q[k] <= flt_d[k];
        pg_q[k]  <= pg_d[k];
      end
    end
  end

  assign o_power_good_out_a = pg_q[0];
  assign o_power_good_out_b = pg_q[1];
  assign o_fault_latch_a    = flt_q[0];
  assign o_fault_latch_b    = flt_q[1];

endmodule // pgs_power_good
`default_nettype wire

// file: core/pgs_pkg.sv
// Package with constants and carrier types of the power-good signal logic.
package pgs_pkg;
  localparam int unsigned CLK_MHZ       = 100;
  localparam int unsigned GATE_TIME_US  = 800;
  localparam int unsigned GATE_CYCLES   = GATE_TIME_US * CLK_MHZ;
  localparam int unsigned RISE_DELAY_MS = 11;
  localparam int unsigned RISE_CYCLES   = RISE_DELAY_MS * 1000 * CLK_MHZ;
  localparam int unsigned N_RAIL        = 3;
  localparam int unsigned N_FLT         = 9;
  localparam int unsigned N_SEL         = 7;
  // Fault bit positions; rails occupy 0 to 2.
  localparam int unsigned FLT_ANALOG_SUPPLY_INPUT  = 3;
  localparam int unsigned FLT_EXTERNAL_MONITOR_ONE = 4;
  localparam int unsigned FLT_EXTERNAL_MONITOR_TWO = 5;
  localparam int unsigned FLT_TWARN = 6;
  localparam int unsigned FLT_TSD   = 7;
  localparam int unsigned FLT_OVP   = 8;
  localparam logic [8:0] FLT_RST = 9'h000;
  localparam logic       PG_RST  = 1'b0;
  localparam logic       MODE_GATED = 1'b0;
  localparam logic       MODE_CONT  = 1'b1;
  typedef struct packed {
    logic enabled;
    logic mon_en;
    logic uv_ok;
    logic ov_ok;
    logic start_dly;
    logic v_change;
    logic ramping;
  } pgs_rail_t;
  typedef struct packed {
    logic       gated_or_continuous_sel;
    logic       fault_holds_output;
    logic       assert_delay_option;
    logic [6:0] src_sel;
  } pgs_cfg_t;
  typedef enum logic [1:0] {
    ST_LOAD = 2'b00,
    ST_WAIT = 2'b01,
    ST_RUN  = 2'b10
  } pgs_state_t;
endpackage

// file: core/pgs_rail_gate.sv
// Per-rail masking window timer for gated power-good mode.
`timescale 1ns/1ns
`default_nettype none
module pgs_rail_gate #(
  parameter int unsigned CYCLES = pgs_pkg::GATE_CYCLES,
  parameter int unsigned W      = $clog2(CYCLES + 1)
) (
  input  wire logic i_core_clk,
  input  wire logic i_nrst,
  input  wire logic i_ce,
  input  wire logic i_en,
  input  wire logic i_restart,
  input  wire logic i_hold,
  output var  logic o_open
);
  logic [W-1:0] cnt_q;
  logic         en_q;
  wire          start_w = (i_en & ~en_q) | i_restart | i_hold;
  localparam logic [W-1:0] LOAD = W'(CYCLES);

  // Restart on enable, on each voltage change and while start-up delay runs.
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      cnt_q <= '0;
      en_q  <= 1'b0;
    end else if (i_ce) begin
      en_q <= i_en;
      if (!i_en) cnt_q <= '0;
      else if (start_w) cnt_q <= LOAD;
      else if (cnt_q != '0) cnt_q <= cnt_q - W'(1);
    end
  end

  assign o_open = i_en & (start_w | (cnt_q != '0));
endmodule // pgs_rail_gate
`default_nettype wire

// file: core/pgs_rise_delay.sv
// Optional assertion delay applied to a raw power-good level.
`timescale 1ns/1ns
`default_nettype none
module pgs_rise_delay #(
  parameter int unsigned CYCLES = pgs_pkg::RISE_CYCLES,
  parameter int unsigned W      = $clog2(CYCLES + 1)
) (
  input  wire logic i_core_clk,
  input  wire logic i_nrst,
  input  wire logic i_ce,
  input  wire logic i_good,
  input  wire logic i_option,
  output var  logic o_good
);
  logic [W-1:0] cnt_q;
  localparam logic [W-1:0] LIM = W'(CYCLES);

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) cnt_q <= '0;
    else if (i_ce) begin
      if (!i_good) cnt_q <= '0;
      else if (cnt_q != LIM) cnt_q <= cnt_q + W'(1);
    end
  end

  // Any drop of the raw level restarts the full delay.
  assign o_good = i_good & (~i_option | (cnt_q == LIM));
endmodule // pgs_rise_delay
`default_nettype wire

// file: test/pgs_host_model.sv
// Host model that acknowledges faults by write-one-to-clear pulses.
`timescale 1ns/1ns
`default_nettype none
module pgs_host_model (
  input  wire logic       i_clr_req,
  input  wire logic [8:0] i_fault,
  output var  logic [1:0] o_clr_step_down,
  output var  logic       o_clr_step_up,
  output var  logic [2:0] o_clr_diagnostic,
  output var  logic [2:0] o_clr_top
);
  // Only bits seen set are written, as software that reads before it clears.
  assign o_clr_step_down = i_clr_req ? i_fault[1:0] : 2'h0;
  assign o_clr_step_up = i_clr_req & i_fault[2];
  assign o_clr_diagnostic = i_clr_req ? i_fault[5:3] : 3'h0;
  assign o_clr_top = i_clr_req ? i_fault[8:6] : 3'h0;
endmodule // pgs_host_model
`default_nettype wire

// file: test/pgs_power_good_monitor.sv
// Concurrent checks on the ports of the power-good signal logic.
`timescale 1ns/1ns
`default_nettype none
module pgs_power_good_monitor #(parameter int unsigned GATE_CYCLES = 20, RISE_CYCLES = 50) (
  input wire logic               i_core_clk,
  input wire logic               i_nrst,
  input wire logic               i_otp_busy,
  input wire logic               i_standby_reached,
  input wire pgs_pkg::pgs_rail_t i_rail [pgs_pkg::N_RAIL],
  input wire logic               i_analog_supply_input_ok,
  input wire logic               i_thermal_shutdown,
  input wire logic               i_supply_overvoltage,
  input wire pgs_pkg::pgs_cfg_t  i_cfg_a,
  input wire pgs_pkg::pgs_cfg_t  i_cfg_b,
  input wire logic [2:0]         i_clr_top,
  input wire logic               o_power_good_out_a,
  input wire logic               o_power_good_out_b,
  input wire logic [8:0]         o_fault_latch_a
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  // Four settled cycles put the load and standby steps safely behind.
  sequence s_run;
    (!i_otp_busy && i_standby_reached) [*4];
  endsequence
  a_prerun_low: assert property (!i_standby_reached |=> !o_power_good_out_a)
    else $error("output high before standby");
  a_tsd_latch: assert property (s_run ##0 i_thermal_shutdown |=> o_fault_latch_a[7])
    else $error("shutdown fault not latched");
  a_ovp_drop: assert property (
    s_run ##0 i_supply_overvoltage |=> ##[0:1] !o_power_good_out_b)
    else $error("overvoltage left output high");
  a_fault_keep: assert property (
    o_fault_latch_a[7] && !i_clr_top[1] && !i_otp_busy |=> o_fault_latch_a[7])
    else $error("shutdown fault lost");
  a_top_clear: assert property (i_clr_top[1] && !i_thermal_shutdown |=> !o_fault_latch_a[7])
    else $error("shutdown fault not cleared");
  a_supply_latch: assert property (
    s_run ##0 !i_analog_supply_input_ok && i_cfg_a.src_sel[3]
      |=> o_fault_latch_a[3] ##[0:1] !o_power_good_out_a)
    else $error("supply fault not reported");
  a_cont_enable: assert property (
    $rose(i_rail[0].enabled) && i_rail[0].mon_en && !i_rail[0].uv_ok
      && i_cfg_b.gated_or_continuous_sel && i_cfg_b.src_sel[0] |=> ##[0:1] !o_power_good_out_b)
    else $error("continuous output high at enable");
  a_gate_mask: assert property (
    $rose(i_rail[0].enabled) && !i_cfg_a.gated_or_continuous_sel && i_cfg_a.src_sel == 7'h01
      && o_power_good_out_a |=> o_power_good_out_a [*8])
    else $error("gated output dropped in window");
endmodule // pgs_power_good_monitor
bind pgs_power_good pgs_power_good_monitor #(.GATE_CYCLES(GATE_CYCLES), .RISE_CYCLES(RISE_CYCLES))
  pgs_power_good_monitor_inst (.i_core_clk, .i_nrst, .i_otp_busy, .i_standby_reached, .i_rail,
  .i_analog_supply_input_ok, .i_thermal_shutdown, .i_supply_overvoltage, .i_cfg_a, .i_cfg_b,
  .i_clr_top, .o_power_good_out_a, .o_power_good_out_b, .o_fault_latch_a);
`default_nettype wire

// file: test/pgs_power_good_tb.sv
// Self-checking testbench of the power-good signal logic.
`timescale 1ns/1ns
`default_nettype none
module pgs_power_good_tb;
  logic clk = 1'b0, nrst = 1'b0, otp = 1'b1, stby = 1'b0, wsel = 1'b0;
  logic analog_supply_input = 1'b1, one = 1'b1, tsd = 1'b0, ovp = 1'b0, req = 1'b0;
  logic pg_a, pg_b, c_su;
  logic [1:0] c_sd;
  logic [2:0] c_dg, c_tp;
  logic [8:0] f_a, f_b;
  int failures = 0, n_tests = 0, cyc_cnt = 0;
  pgs_pkg::pgs_rail_t rail [pgs_pkg::N_RAIL];
  pgs_pkg::pgs_cfg_t cfg_a, cfg_b;
  always #5 clk = ~clk;
  pgs_power_good #(.GATE_CYCLES(20), .RISE_CYCLES(50)) pgs_power_good_inst (
    .i_core_clk(clk), .i_nrst(nrst), .i_ce(one), .i_otp_busy(otp), .i_standby_reached(stby),
    .i_rail(rail), .i_window_check_sel(wsel), .i_analog_supply_input_ok(analog_supply_input),
    .i_external_monitor_one_ok(one), .i_external_monitor_two_ok(one), .i_thermal_warn(~one),
    .i_thermal_shutdown(tsd), .i_supply_overvoltage(ovp), .i_cfg_a(cfg_a), .i_cfg_b(cfg_b),
    .i_clr_step_down(c_sd), .i_clr_step_up(c_su), .i_clr_diagnostic(c_dg), .i_clr_top(c_tp),
    .o_power_good_out_a(pg_a), .o_power_good_out_b(pg_b), .o_fault_latch_a(f_a),
    .o_fault_latch_b(f_b));
  pgs_host_model pgs_host_model_inst (.i_clr_req(req), .i_fault(f_a | f_b),
    .o_clr_step_down(c_sd), .o_clr_step_up(c_su), .o_clr_diagnostic(c_dg), .o_clr_top(c_tp));
  task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic pg(input int n, input logic [1:0] exp);
    cyc(n);
    chk("pg_a_b", {pg_a, pg_b}, exp);
  endtask
  task automatic clr();
    req = 1'b1;
    cyc(1);
    req = 1'b0;
    cyc(3);
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 2000) begin
      failures++;
      close_out();
    end
  end
  initial begin
    foreach (rail[i]) rail[i] = '0;
    cfg_a = '{1'b0, 1'b0, 1'b0, 7'h01};
    cfg_b = '{1'b1, 1'b0, 1'b0, 7'h01};
    cyc(2);
    nrst = 1'b1;
    pg(3, 2'b00);
    {otp, stby} = 2'b01;
    pg(4, 2'b11);
    $display("test startup done");
    rail[0] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
    pg(10, 2'b10);
    pg(15, 2'b00);
    chk("f_a", f_a, 9'h001);
    rail[0].uv_ok = 1'b1;
    pg(3, 2'b01);
    clr();
    pg(0, 2'b11);
    wsel = 1'b1;
    pg(3, 2'b00);
    rail[0].ov_ok = 1'b1;
    clr();
    // A voltage request restarts the gated window, so only the ramp is seen.
    cfg_b.assert_delay_option = 1'b1;
    {rail[0].ramping, rail[0].v_change} = 2'b11;
    cyc(1);
    rail[0].v_change = 1'b0;
    pg(2, 2'b10);
    rail[0].ramping = 1'b0;
    pg(30, 2'b10);
    pg(30, 2'b11);
    cfg_b = '{1'b1, 1'b1, 1'b0, 7'h01};
    rail[0].uv_ok = 1'b0;
    cyc(3);
    rail[0].uv_ok = 1'b1;
    pg(3, 2'b00);
    clr();
    pg(0, 2'b11);
    $display("test rail done");
    {tsd, ovp} = 2'b11;
    cyc(1);
    {tsd, ovp} = 2'b00;
    pg(3, 2'b00);
    chk("f_b", f_b, 9'h180);
    clr();
    pg(0, 2'b11);
    cfg_a.src_sel = 7'h09;
    analog_supply_input = 1'b0;
    pg(3, 2'b01);
    chk("f_a", f_a, 9'h008);
    analog_supply_input = 1'b1;
    pg(3, 2'b01);
    clr();
    pg(0, 2'b11);
    // A ramp that settles inside the window never trips gated mode.
    {rail[0].enabled, rail[0].uv_ok} = 2'b00;
    pg(2, 2'b11);
    rail[0].enabled = 1'b1;
    pg(10, 2'b10);
    rail[0].uv_ok = 1'b1;
    pg(15, 2'b10);
    clr();
    pg(0, 2'b11);
    $display("test faults done");
    close_out();
  end
endmodule // pgs_power_good_tb
`default_nettype wire
